// ### hdl/afh_pkg.sv
// constants, register map and types for the fifo pin controller
package afh_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 8;
    // device timing, ns
    localparam int RESET_SETUP_TIME_NS    = 30;
    localparam int RESET_RECOVERY_TIME_NS = 15;
    localparam int RESET_CYCLE_TIME_NS    = 65;
    localparam int RESET_PULSE_NS         = 50;
    localparam int REPLAY_SETUP_NS        = 30;
    localparam int REPLAY_RECOVERY_TIME_NS = 15;
    localparam int REPLAY_CYCLE_NS        = 65;
    localparam int REPLAY_PULSE_NS        = 50;
    localparam int STROBE_PULSE_NS        = 50;
    localparam int STROBE_RECOVERY_NS     = 15;
    localparam int ACCESS_NS              = 50;
    localparam int FLAG_DELAY_NS          = 45;
    // least times rounded up to whole cycles
    localparam int SYNC_STAGES   = 2;
    localparam int RS_SETUP_CYC  = (RESET_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RS_PULSE_CYC  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RS_LOW_CYC    = (RS_PULSE_CYC > RS_SETUP_CYC) ? RS_PULSE_CYC : RS_SETUP_CYC;
    localparam int RS_REC_CYC    = (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RS_CYCLE_CYC  = (RESET_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RT_SETUP_CYC  = (REPLAY_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RT_PULSE_CYC  = (REPLAY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RT_LOW_CYC    = (RT_PULSE_CYC > RT_SETUP_CYC) ? RT_PULSE_CYC : RT_SETUP_CYC;
    localparam int RT_REC_CYC    = (REPLAY_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RT_CYCLE_CYC  = (REPLAY_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_LOW_CYC    = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LOW_CYC    = ACCESS_CYC + SYNC_STAGES;
    localparam int STB_REC_CYC   = (STROBE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLAG_CYC      = (FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC    = FLAG_CYC + SYNC_STAGES;
    localparam int POST_RS_CYC   = RS_CYCLE_CYC - RS_LOW_CYC + SYNC_STAGES;
    localparam int POST_RT_CYC   = RT_CYCLE_CYC - RT_LOW_CYC + SYNC_STAGES;
    localparam int TMR_W         = 5;
    // widths
    localparam int WORD_W   = 9;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int FIFO_DEPTH = 2048;
    // register offsets
    localparam logic [ADDR_W-1:0] CFG_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] CMD_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] WDATA_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] RDATA_OFS  = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
    // command bits
    localparam int CMD_RESET_BIT  = 0;
    localparam int CMD_REPLAY_BIT = 1;
    localparam int CMD_POP_BIT    = 2;
    // status bits
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_EMPTY_BIT = 2;
    localparam int ST_FULL_BIT  = 3;
    localparam int ST_HALF_BIT  = 4;
    localparam int ST_CHAIN_BIT = 5;
    localparam int ST_VALID_BIT = 6;
    localparam int ST_ERR_LSB   = 8;
    localparam int ERR_W        = 4;
    localparam int ERR_FULL     = 0;
    localparam int ERR_EMPTY    = 1;
    localparam int ERR_REPLAY   = 2;
    localparam int ERR_ORDER    = 3;
    // reset values
    localparam logic [1:0] CFG_RST = 2'h0;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_WIDTH  = 2'h1,
        MODE_HEAD   = 2'h2,
        MODE_FOLLOW = 2'h3
    } afh_mode_t;
    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001,
        ST_RS_LOW = 10'h002,
        ST_RS_REC = 10'h004,
        ST_RS_SET = 10'h008,
        ST_WR_LOW = 10'h010,
        ST_WR_SET = 10'h020,
        ST_RD_LOW = 10'h040,
        ST_RD_SET = 10'h080,
        ST_RT_LOW = 10'h100,
        ST_RT_SET = 10'h200
    } afh_state_t;
endpackage

// ### hdl/afh_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module afh_sync
    import afh_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         ce,
    // pins in, synchronised out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic meta_nxt;
            logic stab_r;
            logic stab_nxt;
            always_comb begin
                meta_nxt = ce ? d_in[i] : meta_r;
                stab_nxt = ce ? meta_r : stab_r;
            end
            // resets high: the watched flag pins are active low
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    meta_r <= 1'b1;
                    stab_r <= 1'b1;
                end else begin
                    meta_r <= meta_nxt;
                    stab_r <= stab_nxt;
                end
            end
            assign d_out[i] = stab_r;
        end
    endgenerate
endmodule

// ### hdl/afh_timer.sv
// down-counter timing the phases of each pin sequence
`timescale 1ns/1ps
module afh_timer
    import afh_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             ce,
    // load and expiry
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] cnt_in,
    output logic                  done
);
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (ce) begin
            if (load) begin
                cnt_nxt = cnt_in;
            end else if (cnt_r != '0) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    // done in the cycle the count has run down to one
    assign done = (cnt_r == {{(TMR_W-1){1'b0}}, 1'b1});
endmodule

// ### hdl/afh_ctrl.sv
// host controller driving the pins of an asynchronous 2048x9 fifo
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - no push before first reset
// - strobes high around reset, setup and recovery
// - pop high around replay, setup and recovery
// - replay refused in depth expansion
// - parallel controls, flags read from one device
// - depth mode flags combined outside
// - chain head low at reset on first
// - chain head high at reset on others
// - chain output rings to next chain input
module afh_ctrl
    import afh_pkg::*;
(
    // clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // fifo control pins
    output logic                   fifo_reset_n,
    output logic                   push_n,
    output logic                   pop_n,
    output logic                   replay_n,
    output logic                   chain_in_n,
    output logic                   chain_in_oe,
    // fifo data pins
    output logic      [WORD_W-1:0] data_d,
    input  wire logic [WORD_W-1:0] data_q,
    // fifo status pins
    input  wire logic              empty_n,
    input  wire logic              full_n,
    input  wire logic              half_level_n,
    input  wire logic              chain_out_n
);
    localparam int SYNC_W = WORD_W + 4;

    afh_state_t        state_r;
    afh_state_t        state_nxt;
    logic [1:0]        cfg_r;
    logic [1:0]        cfg_nxt;
    afh_mode_t         act_mode_r;
    afh_mode_t         act_mode_nxt;
    logic              ready_r;
    logic              ready_nxt;
    logic              rst_n_r;
    logic              rst_n_nxt;
    logic              push_n_r;
    logic              push_n_nxt;
    logic              pop_n_r;
    logic              pop_n_nxt;
    logic              rt_n_r;
    logic              rt_n_nxt;
    logic [WORD_W-1:0] wdat_r;
    logic [WORD_W-1:0] wdat_nxt;
    logic [WORD_W-1:0] rdat_r;
    logic [WORD_W-1:0] rdat_nxt;
    logic              valid_r;
    logic              valid_nxt;
    logic [ERR_W-1:0]  err_r;
    logic [ERR_W-1:0]  err_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_val;
    logic              tmr_done;
    logic [SYNC_W-1:0] sync_q;
    logic [WORD_W-1:0] q_s;
    logic              empty_s;
    logic              full_s;
    logic              half_s;
    logic              chain_s;
    logic              busy;
    logic              depth_mode;
    logic [ERR_W-1:0]  err_set;
    logic              cmd_wr;
    logic              push_req;

    // flags and read data pass two flip-flops before use
    afh_sync #(.W(SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ce      (ce),
        .d_in    ({chain_out_n, half_level_n, full_n, empty_n, data_q}),
        .d_out   (sync_q)
    );
    assign {chain_s, half_s, full_s, empty_s, q_s} = sync_q;

    afh_timer u_timer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ce      (ce),
        .load    (tmr_load),
        .cnt_in  (tmr_val),
        .done    (tmr_done)
    );

    assign busy       = (state_r != ST_IDLE);
    assign depth_mode = act_mode_r[1];
    assign cmd_wr     = wr && (addr == CMD_OFS);
    assign push_req   = wr && (addr == WDATA_OFS);

    // sequencer
    always_comb begin
        state_nxt    = state_r;
        act_mode_nxt = act_mode_r;
        ready_nxt    = ready_r;
        rst_n_nxt    = rst_n_r;
        push_n_nxt   = push_n_r;
        pop_n_nxt    = pop_n_r;
        rt_n_nxt     = rt_n_r;
        wdat_nxt     = wdat_r;
        rdat_nxt     = rdat_r;
        valid_nxt    = valid_r;
        err_set      = '0;
        tmr_load     = 1'b0;
        tmr_val      = '0;
        case (state_r)
            ST_IDLE: begin
                if (cmd_wr && wdata[CMD_RESET_BIT]) begin
                    // push and pop are already high in idle
                    act_mode_nxt = afh_mode_t'(cfg_r);
                    rst_n_nxt    = 1'b0;
                    // chain head level set up for the reset
                    rt_n_nxt     = (cfg_r == MODE_HEAD) ? 1'b0 : 1'b1;
                    ready_nxt    = 1'b0;
                    valid_nxt    = 1'b0;
                    tmr_load     = 1'b1;
                    tmr_val      = TMR_W'(RS_LOW_CYC);
                    state_nxt    = ST_RS_LOW;
                end else if (cmd_wr && wdata[CMD_REPLAY_BIT]) begin
                    if (!ready_r) begin
                        err_set[ERR_ORDER] = 1'b1;
                    end else if (depth_mode) begin
                        err_set[ERR_REPLAY] = 1'b1;
                    end else begin
                        rt_n_nxt  = 1'b0;
                        tmr_load  = 1'b1;
                        tmr_val   = TMR_W'(RT_LOW_CYC);
                        state_nxt = ST_RT_LOW;
                    end
                end else if (cmd_wr && wdata[CMD_POP_BIT]) begin
                    if (!ready_r) begin
                        err_set[ERR_ORDER] = 1'b1;
                    end else if (!empty_s) begin
                        err_set[ERR_EMPTY] = 1'b1;
                    end else begin
                        pop_n_nxt = 1'b0;
                        valid_nxt = 1'b0;
                        tmr_load  = 1'b1;
                        tmr_val   = TMR_W'(RD_LOW_CYC);
                        state_nxt = ST_RD_LOW;
                    end
                end else if (push_req) begin
                    if (!ready_r) begin
                        err_set[ERR_ORDER] = 1'b1;
                    end else if (!full_s) begin
                        err_set[ERR_FULL] = 1'b1;
                    end else begin
                        wdat_nxt   = wdata[WORD_W-1:0];
                        push_n_nxt = 1'b0;
                        tmr_load   = 1'b1;
                        tmr_val    = TMR_W'(WR_LOW_CYC);
                        state_nxt  = ST_WR_LOW;
                    end
                end
            end
            ST_RS_LOW: begin
                if (tmr_done) begin
                    rst_n_nxt = 1'b1;
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(RS_REC_CYC);
                    state_nxt = ST_RS_REC;
                end
            end
            ST_RS_REC: begin
                if (tmr_done) begin
                    if (!depth_mode) begin
                        rt_n_nxt = 1'b1;
                    end
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(POST_RS_CYC);
                    state_nxt = ST_RS_SET;
                end
            end
            ST_RS_SET: begin
                if (tmr_done) begin
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_WR_LOW: begin
                if (tmr_done) begin
                    push_n_nxt = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_val    = TMR_W'(SETTLE_CYC);
                    state_nxt  = ST_WR_SET;
                end
            end
            ST_RD_LOW: begin
                if (tmr_done) begin
                    // access time met before the synced sample is taken
                    rdat_nxt  = q_s;
                    valid_nxt = 1'b1;
                    pop_n_nxt = 1'b1;
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(SETTLE_CYC);
                    state_nxt = ST_RD_SET;
                end
            end
            ST_RT_LOW: begin
                if (tmr_done) begin
                    rt_n_nxt  = 1'b1;
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(POST_RT_CYC);
                    state_nxt = ST_RT_SET;
                end
            end
            ST_WR_SET, ST_RD_SET, ST_RT_SET: begin
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // a command arriving mid-sequence is dropped and flagged
        if (busy && (cmd_wr || push_req)) begin
            err_set[ERR_ORDER] = 1'b1;
        end
    end

    // register port
    always_comb begin
        cfg_nxt   = cfg_r;
        err_nxt   = err_r;
        rdata_nxt = '0;
        if (wr && (addr == CFG_OFS)) begin
            cfg_nxt = wdata[1:0];
        end
        if (wr && (addr == STATUS_OFS)) begin
            err_nxt = err_r & ~wdata[ST_ERR_LSB +: ERR_W];
        end
        // a new event wins over a clear in the same cycle
        err_nxt = err_nxt | err_set;
        if (rd) begin
            case (addr)
                CFG_OFS:    rdata_nxt = {30'h0, cfg_r};
                WDATA_OFS:  rdata_nxt = {23'h0, wdat_r};
                RDATA_OFS:  rdata_nxt = {23'h0, rdat_r};
                STATUS_OFS: begin
                    rdata_nxt[ST_BUSY_BIT]  = busy;
                    rdata_nxt[ST_READY_BIT] = ready_r;
                    rdata_nxt[ST_EMPTY_BIT] = empty_s;
                    rdata_nxt[ST_FULL_BIT]  = full_s;
                    rdata_nxt[ST_HALF_BIT]  = half_s;
                    rdata_nxt[ST_CHAIN_BIT] = chain_s;
                    rdata_nxt[ST_VALID_BIT] = valid_r;
                    rdata_nxt[ST_ERR_LSB +: ERR_W] = err_r;
                end
                default:    rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r    <= ST_IDLE;
            cfg_r      <= CFG_RST;
            act_mode_r <= MODE_SINGLE;
            ready_r    <= 1'b0;
            rst_n_r    <= 1'b1;
            push_n_r   <= 1'b1;
            pop_n_r    <= 1'b1;
            rt_n_r     <= 1'b1;
            wdat_r     <= '0;
            rdat_r     <= '0;
            valid_r    <= 1'b0;
            err_r      <= '0;
            rdata_r    <= '0;
        end else if (ce) begin
            state_r    <= state_nxt;
            cfg_r      <= cfg_nxt;
            act_mode_r <= act_mode_nxt;
            ready_r    <= ready_nxt;
            rst_n_r    <= rst_n_nxt;
            push_n_r   <= push_n_nxt;
            pop_n_r    <= pop_n_nxt;
            rt_n_r     <= rt_n_nxt;
            wdat_r     <= wdat_nxt;
            rdat_r     <= rdat_nxt;
            valid_r    <= valid_nxt;
            err_r      <= err_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign rdata        = rdata_r;
    assign fifo_reset_n = rst_n_r;
    assign push_n       = push_n_r;
    assign pop_n        = pop_n_r;
    // shared pin: chain head level from reset on in depth mode, replay strobe otherwise
    assign replay_n     = rt_n_r;
    // grounded outside depth mode; in depth mode the ring drives it
    assign chain_in_n   = 1'b0;
    assign chain_in_oe  = !depth_mode;
    assign data_d       = wdat_r;
endmodule

// ### tb/afh_ctrl_properties.sv
// pin-level checks on the fifo controller
`timescale 1ns/1ps
module afh_ctrl_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // device pins
    input wire logic fifo_reset_n,
    input wire logic push_n,
    input wire logic pop_n,
    input wire logic replay_n,
    input wire logic chain_in_n,
    input wire logic chain_in_oe,
    input wire logic empty_n,
    input wire logic full_n
);
    logic seen_r;
    logic seen_nxt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    always_comb seen_nxt = seen_r | ~fifo_reset_n;
    always_ff @(posedge ref_clk) seen_r <= srst ? 1'b0 : seen_nxt;
    property p_rs_setup;
        $rose(fifo_reset_n) |-> $past(push_n, 1) && $past(pop_n, 1) && $past(push_n, 4) && $past(pop_n, 4)
            ##1 (push_n && pop_n)[*2];
    endproperty
    a_rs_setup: assert property (p_rs_setup) else $error("strobe low near reset release");
    property p_rs_width;
        $fell(fifo_reset_n) |-> (!fifo_reset_n)[*7];
    endproperty
    a_rs_width: assert property (p_rs_width) else $error("reset pulse too short");
    property p_rt_guard;
        $rose(replay_n) |-> $past(pop_n, 4) && pop_n ##1 pop_n ##1 pop_n;
    endproperty
    a_rt_guard: assert property (p_rt_guard) else $error("pop low near replay release");
    property p_rt_depth;
        $fell(replay_n) && fifo_reset_n |-> chain_in_oe;
    endproperty
    a_rt_depth: assert property (p_rt_depth) else $error("replay in chained mode");
    property p_push_first;
        $fell(push_n) |-> seen_r;
    endproperty
    a_push_first: assert property (p_push_first) else $error("push before device reset");
    property p_push_full;
        $fell(push_n) |-> full_n && $past(full_n, 2);
    endproperty
    a_push_full: assert property (p_push_full) else $error("push while full");
    property p_pop_empty;
        $fell(pop_n) |-> empty_n && $past(empty_n, 2);
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("pop while empty");
    property p_single_sel;
        $rose(fifo_reset_n) && chain_in_oe |-> !chain_in_n && !$past(chain_in_n, 3);
    endproperty
    a_single_sel: assert property (p_single_sel) else $error("chain input not low at release");
endmodule

bind afh_ctrl afh_ctrl_properties u_props (.ref_clk(ref_clk), .srst(srst), .fifo_reset_n(fifo_reset_n),
    .push_n(push_n), .pop_n(pop_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
    .chain_in_oe(chain_in_oe), .empty_n(empty_n), .full_n(full_n));

// ### tb/afh_fifo_model.sv
// behavioural model of the 2048x9 fifo device
`timescale 1ns/1ps
module afh_fifo_model #(
    parameter int FLAG_DLY = 40
) (
    // control pins
    input  wire logic       rst_n,
    input  wire logic       push_n,
    input  wire logic       pop_n,
    input  wire logic       replay_n,
    input  wire logic       chain_in_n,
    // data and flags
    input  wire logic [8:0] d,
    output logic      [8:0] q,
    output logic            empty_n,
    output logic            full_n,
    output logic            half_n,
    output logic            chain_out_n
);
    logic [8:0]  mem [2048];
    logic [10:0] wp, rp;
    int          cnt;
    logic        depth, armed, wok, rok;
    // slow flags on purpose: the controller must wait out its settle time
    task automatic flags();
        empty_n <= #FLAG_DLY (cnt != 0);
        full_n  <= #FLAG_DLY (cnt != 2048);
    endtask
    initial begin
        {wp, rp, depth, armed, wok, rok} = '0;
        cnt = 0;
        q = 9'h155;
        {empty_n, full_n, half_n, chain_out_n} = 4'h7;
    end
    // chain output pulses not modelled: ring of devices is outside this bench
    always @(rst_n) begin
        if (!rst_n) begin
            wp = '0;
            rp = '0;
            cnt = 0;
            half_n <= #FLAG_DLY 1'b1;
            flags();
        end else begin
            depth = chain_in_n;
            armed = !depth || !replay_n;
        end
    end
    always @(negedge replay_n) begin
        if (rst_n && !depth) begin
            rp = '0;
            cnt = int'(wp);
            flags();
        end
    end
    always @(negedge chain_in_n) begin
        if (rst_n) begin
            armed = 1'b1;
        end
    end
    always @(negedge push_n) begin
        wok = rst_n && full_n && armed;
        if (wok) begin
            cnt = cnt + 1;
            flags();
            if (cnt > 1024 && !depth) begin
                half_n <= #FLAG_DLY 1'b0;
            end
        end
    end
    always @(posedge push_n) begin
        if (wok) begin
            mem[wp] = d;
            wp = wp + 11'h001;
        end
    end
    always @(negedge pop_n) begin
        rok = rst_n && empty_n;
        if (rok) begin
            q = mem[rp];
            rp = rp + 11'h001;
            cnt = cnt - 1;
            flags();
        end
    end
    always @(posedge pop_n) begin
        q = ~q; // released bus shows no stale word
        if (rok && cnt <= 1024) begin
            half_n <= #FLAG_DLY 1'b1;
        end
    end
endmodule

// ### tb/afh_ctrl_bench.sv
// self-checking bench for the fifo controller
`timescale 1ns/1ps
module afh_ctrl_bench
    import afh_pkg::*;
;
    logic              ref_clk, srst, wr, rd, chk_r, pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, seed;
    logic              fifo_reset_n, push_n, pop_n, replay_n, chain_in_n, chain_in_oe;
    logic              empty_n, full_n, half_level_n, chain_out_n;
    logic [WORD_W-1:0] data_d, data_q, first_w;
    logic [63:0]       exp_q[$];
    logic [8:0]        word_q[$];
    logic [63:0]       e;
    int                failures, num_checks;
    wire               chain_w = chain_in_oe ? chain_in_n : 1'b1; // pulled up when released
    afh_ctrl dut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .fifo_reset_n(fifo_reset_n), .push_n(push_n), .pop_n(pop_n), .replay_n(replay_n),
        .chain_in_n(chain_in_n), .chain_in_oe(chain_in_oe), .data_d(data_d), .data_q(data_q),
        .empty_n(empty_n), .full_n(full_n), .half_level_n(half_level_n), .chain_out_n(chain_out_n));
    afh_fifo_model dev (.rst_n(fifo_reset_n), .push_n(push_n), .pop_n(pop_n), .replay_n(replay_n),
        .chain_in_n(chain_w), .d(data_d), .q(data_q), .empty_n(empty_n), .full_n(full_n),
        .half_n(half_level_n), .chain_out_n(chain_out_n));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input int gap);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        // a zero gap holds the strobe for the next write
        if (gap > 0) begin
            wr <= 1'b0;
        end
        repeat (gap) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] v);
        addr  <= a;
        rd    <= 1'b1;
        chk_r <= 1'b1;
        exp_q.push_back({32'hFFFF_FFFF, v});
        @(posedge ref_clk);
        rd    <= 1'b0;
        chk_r <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic push(input int n);
        logic [31:0] v;
        repeat (n) begin
            v = rnd();
            word_q.push_back(v[8:0]);
            wr_reg(WDATA_OFS, v, 17);
        end
    endtask
    task automatic pop_chk();
        wr_reg(CMD_OFS, 32'h0000_0004, 19);
        chk(RDATA_OFS, {23'h000000, word_q.pop_front()});
    endtask
    task automatic end_test(input string s);
        wr_reg(STATUS_OFS, 32'h0000_0F00, 1);
        $display("test %s done", s);
    endtask
    always @(posedge ref_clk) begin
        if (pend) begin
            e = exp_q.pop_front();
            num_checks++;
            if ((rdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
                failures++;
                $display("wrong value at %0t ns: read %h, expected %h", $time, rdata, e[31:0]);
            end
        end
        pend = rd && chk_r;
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        $display("wrong value at %0t ns: run did not finish", $time);
        finish_test();
    end
    initial begin
        {srst, wr, rd, chk_r, pend} = 5'h10;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        seed = 32'h0001_58CF;
        failures = 0;
        num_checks = 0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        wr_reg(WDATA_OFS, rnd(), 2);
        chk(STATUS_OFS, 32'h0000_0838);
        end_test("order");
        wr_reg(CMD_OFS, 32'h0000_0001, 14);
        chk(STATUS_OFS, 32'h0000_003A);
        wr_reg(CMD_OFS, 32'h0000_0004, 19);
        chk(STATUS_OFS, 32'h0000_023A);
        end_test("reset");
        push(3);
        first_w = word_q[0];
        pop_chk();
        pop_chk();
        wr_reg(CMD_OFS, 32'h0000_0002, 12);
        chk(STATUS_OFS, 32'h0000_007E);
        wr_reg(CMD_OFS, 32'h0000_0004, 19);
        chk(RDATA_OFS, {23'h000000, first_w});
        end_test("replay");
        wr_reg(CMD_OFS, 32'h0000_0001, 14);
        word_q.delete();
        push(1025);
        chk(STATUS_OFS, 32'h0000_002E);
        pop_chk();
        chk(STATUS_OFS, 32'h0000_007E);
        push(1024);
        chk(STATUS_OFS, 32'h0000_0066);
        wr_reg(WDATA_OFS, rnd(), 17);
        chk(STATUS_OFS, 32'h0000_0166);
        pop_chk();
        end_test("fill");
        wr_reg(CFG_OFS, 32'h0000_0001, 0);
        wr_reg(CMD_OFS, 32'h0000_0001, 14);
        chk(CFG_OFS, 32'h0000_0001);
        push(1);
        chk(STATUS_OFS, 32'h0000_003E);
        wr_reg(CFG_OFS, 32'h0000_0002, 0);
        wr_reg(CMD_OFS, 32'h0000_0001, 14);
        wr_reg(CMD_OFS, 32'h0000_0002, 12);
        chk(STATUS_OFS, 32'h0000_043A);
        push(1025);
        chk(STATUS_OFS, 32'h0000_043E);
        wr_reg(CFG_OFS, 32'h0000_0003, 0);
        wr_reg(CMD_OFS, 32'h0000_0001, 14);
        push(1);
        chk(STATUS_OFS, 32'h0000_043A);
        end_test("modes");
        finish_test();
    end
endmodule
